// ===== hdl/mie_pkg.sv
package mie_pkg;
  localparam int DATA_W      = 8;
  localparam int PC_W        = 13;
  localparam int OPC_W       = 5;
  localparam int BIT_SEL_W   = 3;
  localparam int NIB_LIMIT   = 9;
  localparam logic [3:0] NIB_FIX = 4'h6;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [12:0] RST_PC = 13'h0000;
  localparam int CYC_SINGLE  = 1;
  localparam int CYC_BRANCH  = 2;

  typedef enum logic [4:0] {
    MIE_OP_NOP        = 5'h00,
    MIE_OP_CALL       = 5'h01,
    MIE_OP_JUMP       = 5'h02,
    MIE_OP_ZERO_FILL  = 5'h03,
    MIE_OP_ZERO_BIT   = 5'h04,
    MIE_OP_WD_CLEAR   = 5'h05,
    MIE_OP_CPL        = 5'h06,
    MIE_OP_CPL_ACC    = 5'h07,
    MIE_OP_DEC_ADJ    = 5'h08,
    MIE_OP_DEC        = 5'h09,
    MIE_OP_DEC_ACC    = 5'h0A,
    MIE_OP_HALT       = 5'h0B,
    MIE_OP_INC        = 5'h0C,
    MIE_OP_INC_ACC    = 5'h0D,
    MIE_OP_MOVE_TO_A  = 5'h0E,
    MIE_OP_MOVE_IMM   = 5'h0F,
    MIE_OP_MOVE_TO_M  = 5'h10
  } mie_op_t;

  typedef enum logic [1:0] {
    MIE_ST_RUN   = 2'b00,
    MIE_ST_DUMMY = 2'b01,
    MIE_ST_HALT  = 2'b10
  } mie_state_t;
endpackage

// ===== hdl/mie_alu.sv
`timescale 1ns/10ps
module mie_alu (
  input  wire logic [4:0] i_op,
  input  wire logic [7:0] i_mem,
  input  wire logic [7:0] i_acc,
  input  wire logic [2:0] i_bit,
  input  wire logic       i_carry,
  input  wire logic       i_aux_carry,
  output logic      [7:0] o_result,
  output logic            o_carry
);
  logic [7:0] mask;
  logic [7:0] fix;
  logic [8:0] adj;

  always_comb begin
    mask     = 8'h01 << i_bit;
    fix      = mie_pkg::ZERO_BYTE;
    if ((i_acc[3:0] > 4'(mie_pkg::NIB_LIMIT)) || i_aux_carry) begin
      fix[3:0] = mie_pkg::NIB_FIX;
    end
    if ((i_acc[7:4] > 4'(mie_pkg::NIB_LIMIT)) || i_carry) begin
      fix[7:4] = mie_pkg::NIB_FIX;
    end
    adj      = {1'b0, i_acc} + {1'b0, fix};
    o_carry  = i_carry;
    o_result = i_mem;
    unique case (mie_pkg::mie_op_t'(i_op))
      mie_pkg::MIE_OP_ZERO_FILL: o_result = mie_pkg::ZERO_BYTE;
      mie_pkg::MIE_OP_ZERO_BIT:  o_result = i_mem & ~mask;
      mie_pkg::MIE_OP_CPL,
      mie_pkg::MIE_OP_CPL_ACC:   o_result = ~i_mem;
      mie_pkg::MIE_OP_DEC,
      mie_pkg::MIE_OP_DEC_ACC:   o_result = i_mem - 8'h01;
      mie_pkg::MIE_OP_INC,
      mie_pkg::MIE_OP_INC_ACC:   o_result = i_mem + 8'h01;
      mie_pkg::MIE_OP_MOVE_TO_M: o_result = i_acc;
      mie_pkg::MIE_OP_DEC_ADJ: begin
        o_result = adj[7:0];
        o_carry  = i_carry | adj[8];
      end
      default:                   o_result = i_mem;
    endcase
  end
endmodule

// ===== hdl/mie_core.sv
`timescale 1ns/10ps
// Behaviour
// - call pushes pc plus one, loads target
// - call takes two cycles, no flags
// - zero fill writes 00 to byte
// - bit clear zeroes only selected bit
// - watchdog clear clears counter, timeout, powerdown
// - complement inverts memory byte, updates zero
// - complement to acc, memory kept, zero
// - low nibble over 9 or aux adds 6
// - high nibble over 9 or carry adds 6
// - correction 00/06/60/66, only carry changes
// - decrement memory byte, update zero
// - decrement into acc, memory kept, zero
// - halt stops execution, gates clock, retains state
// - halt clears watchdog, prescaler, sets powerdown
// - increment memory byte, update zero
// - increment into acc, memory kept, zero
// - jump loads pc, dummy cycle, no flags
// - move memory to acc, no flags
// - move immediate to acc, no flags
// - move acc to memory, no flags
// - plain ops one cycle, pc writes two
module mie_core #(
  parameter int PC_W = mie_pkg::PC_W
) (
  input  wire logic            i_clock,
  input  wire logic            i_rst_n,
  input  wire logic            i_valid,
  input  wire logic [4:0]      i_op,
  input  wire logic [7:0]      i_mem_rdata,
  input  wire logic [7:0]      i_imm,
  input  wire logic [2:0]      i_bit,
  input  wire logic [PC_W-1:0] i_target,
  input  wire logic [PC_W-1:0] i_pc,
  input  wire logic            i_carry,
  input  wire logic            i_aux_carry,
  input  wire logic            i_wake,
  output logic                 o_ready,
  output logic [7:0]           o_work_accumulator,
  output logic                 o_mem_we,
  output logic [7:0]           o_mem_wdata,
  output logic                 o_zero_we,
  output logic                 o_zero_flag,
  output logic                 o_carry_we,
  output logic                 o_carry_flag,
  output logic                 o_pc_load,
  output logic [PC_W-1:0]      o_pc_next,
  output logic                 o_stack_push,
  output logic [PC_W-1:0]      o_stack_data,
  output logic                 o_watchdog_clear,
  output logic                 o_prescaler_clear,
  output logic                 o_timeout_flag,
  output logic                 o_powerdown_flag,
  output logic                 o_clock_gate_off
);
  ////////////////////////////////////////////////////////////////////////////
  mie_pkg::mie_state_t state;
  mie_pkg::mie_state_t next_state;
  mie_pkg::mie_op_t    op;
  logic [7:0]          result;
  logic                carry_out;
  logic                take;
  logic [7:0]          next_acc;
  logic                acc_we;
  logic                mem_we;
  logic                zero_we;

  assign op   = mie_pkg::mie_op_t'(i_op);
  assign take = i_valid && (state == mie_pkg::MIE_ST_RUN);

  mie_alu u_alu (
    .i_op        (i_op),
    .i_mem       (i_mem_rdata),
    .i_acc       (o_work_accumulator),
    .i_bit       (i_bit),
    .i_carry     (i_carry),
    .i_aux_carry (i_aux_carry),
    .o_result    (result),
    .o_carry     (carry_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    acc_we   = 1'b0;
    mem_we   = 1'b0;
    zero_we  = 1'b0;
    next_acc = o_work_accumulator;
    unique case (op)
      mie_pkg::MIE_OP_ZERO_FILL,
      mie_pkg::MIE_OP_ZERO_BIT,
      mie_pkg::MIE_OP_MOVE_TO_M: mem_we = 1'b1;
      mie_pkg::MIE_OP_DEC_ADJ:   mem_we = 1'b1;
      mie_pkg::MIE_OP_CPL,
      mie_pkg::MIE_OP_DEC,
      mie_pkg::MIE_OP_INC: begin
        mem_we  = 1'b1;
        zero_we = 1'b1;
      end
      mie_pkg::MIE_OP_CPL_ACC,
      mie_pkg::MIE_OP_DEC_ACC,
      mie_pkg::MIE_OP_INC_ACC: begin
        acc_we   = 1'b1;
        zero_we  = 1'b1;
        next_acc = result;
      end
      mie_pkg::MIE_OP_MOVE_TO_A: begin
        acc_we   = 1'b1;
        next_acc = i_mem_rdata;
      end
      mie_pkg::MIE_OP_MOVE_IMM: begin
        acc_we   = 1'b1;
        next_acc = i_imm;
      end
      default: begin
        acc_we   = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    unique case (state)
      mie_pkg::MIE_ST_RUN: begin
        if (take && (op == mie_pkg::MIE_OP_CALL || op == mie_pkg::MIE_OP_JUMP)) begin
          next_state = mie_pkg::MIE_ST_DUMMY;
        end else if (take && op == mie_pkg::MIE_OP_HALT) begin
          next_state = mie_pkg::MIE_ST_HALT;
        end
      end
      mie_pkg::MIE_ST_DUMMY: next_state = mie_pkg::MIE_ST_RUN;
      mie_pkg::MIE_ST_HALT: begin
        if (i_wake) begin
          next_state = mie_pkg::MIE_ST_RUN;
        end
      end
      default: next_state = mie_pkg::MIE_ST_RUN;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state <= mie_pkg::MIE_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_ready          <= 1'b0;
      o_clock_gate_off <= 1'b0;
    end else begin
      o_ready          <= (next_state == mie_pkg::MIE_ST_RUN);
      o_clock_gate_off <= (next_state == mie_pkg::MIE_ST_HALT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_work_accumulator <= mie_pkg::RST_ACC;
    end else if (take && acc_we) begin
      o_work_accumulator <= next_acc;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_mem_we    <= 1'b0;
      o_mem_wdata <= mie_pkg::ZERO_BYTE;
    end else begin
      o_mem_we    <= take && mem_we;
      if (take && mem_we) begin
        o_mem_wdata <= result;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_zero_we    <= 1'b0;
      o_zero_flag  <= 1'b0;
      o_carry_we   <= 1'b0;
      o_carry_flag <= 1'b0;
    end else begin
      o_zero_we    <= take && zero_we;
      o_carry_we   <= take && (op == mie_pkg::MIE_OP_DEC_ADJ);
      if (take && zero_we) begin
        o_zero_flag <= (result == mie_pkg::ZERO_BYTE);
      end
      if (take && op == mie_pkg::MIE_OP_DEC_ADJ) begin
        o_carry_flag <= carry_out;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_pc_load    <= 1'b0;
      o_pc_next    <= mie_pkg::RST_PC[PC_W-1:0];
      o_stack_push <= 1'b0;
      o_stack_data <= mie_pkg::RST_PC[PC_W-1:0];
    end else begin
      o_pc_load    <= take && (op == mie_pkg::MIE_OP_CALL || op == mie_pkg::MIE_OP_JUMP);
      o_stack_push <= take && (op == mie_pkg::MIE_OP_CALL);
      if (take && (op == mie_pkg::MIE_OP_CALL || op == mie_pkg::MIE_OP_JUMP)) begin
        o_pc_next <= i_target;
      end
      if (take && op == mie_pkg::MIE_OP_CALL) begin
        o_stack_data <= i_pc + PC_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_watchdog_clear  <= 1'b0;
      o_prescaler_clear <= 1'b0;
      o_timeout_flag    <= 1'b0;
      o_powerdown_flag  <= 1'b0;
    end else begin
      o_watchdog_clear  <= take && (op == mie_pkg::MIE_OP_WD_CLEAR || op == mie_pkg::MIE_OP_HALT);
      o_prescaler_clear <= take && (op == mie_pkg::MIE_OP_HALT);
      if (take && op == mie_pkg::MIE_OP_WD_CLEAR) begin
        o_timeout_flag   <= 1'b0;
        o_powerdown_flag <= 1'b0;
      end else if (take && op == mie_pkg::MIE_OP_HALT) begin
        o_timeout_flag   <= 1'b0;
        o_powerdown_flag <= 1'b1;
      end
    end
  end
endmodule

// ===== testbench/mie_core_properties.sv
`timescale 1ns/10ps
module mie_core_chk #(
  parameter int PC_W = 13
) (
  input wire logic            i_clock,
  input wire logic            i_rst_n,
  input wire logic            i_valid,
  input wire logic [4:0]      i_op,
  input wire logic [7:0]      i_mem_rdata,
  input wire logic [PC_W-1:0] i_pc,
  input wire logic            i_wake,
  input wire logic            o_ready,
  input wire logic [7:0]      o_work_accumulator,
  input wire logic            o_mem_we,
  input wire logic [7:0]      o_mem_wdata,
  input wire logic            o_zero_we,
  input wire logic            o_zero_flag,
  input wire logic            o_carry_we,
  input wire logic            o_pc_load,
  input wire logic [PC_W-1:0] o_stack_data,
  input wire logic            o_watchdog_clear,
  input wire logic            o_timeout_flag,
  input wire logic            o_powerdown_flag,
  input wire logic            o_clock_gate_off
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic tk;
  assign tk = i_valid && o_ready;
  property p_call; tk && i_op == 5'h01 |=> o_stack_data == $past(i_pc) + 1'b1; endproperty
  a_call: assert property (p_call) else $error("bad return address");
  property p_dummy; o_pc_load |-> !o_ready ##1 o_ready; endproperty
  a_dummy: assert property (p_dummy) else $error("no single dummy cycle");
  property p_halt; tk && i_op == 5'h0B |=>
    o_clock_gate_off && o_powerdown_flag && !o_timeout_flag && o_watchdog_clear; endproperty
  a_halt: assert property (p_halt) else $error("halt flags wrong");
  property p_stay; o_clock_gate_off && !i_wake |=> o_clock_gate_off && !o_mem_we; endproperty
  a_stay: assert property (p_stay) else $error("left halt early");
  property p_wdc; tk && i_op == 5'h05 |=>
    o_watchdog_clear && !o_timeout_flag && !o_powerdown_flag; endproperty
  a_wdc: assert property (p_wdc) else $error("watchdog clear wrong");
  property p_zero; o_zero_we |->
    o_zero_flag == (o_mem_we ? o_mem_wdata == 8'h00 : o_work_accumulator == 8'h00); endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_clr; tk && i_op == 5'h03 |=> o_mem_we && o_mem_wdata == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("clear byte wrong");
  property p_inc; tk && i_op == 5'h0C |=> o_mem_wdata == $past(i_mem_rdata) + 8'h01; endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_branch; tk && (i_op == 5'h01 || i_op == 5'h02) |=>
    o_pc_load && !o_zero_we && !o_carry_we && !o_mem_we; endproperty
  a_branch: assert property (p_branch) else $error("branch touched flags");
  property p_complement_to_acc_op; tk && i_op == 5'h07 |=>
    o_work_accumulator == ~$past(i_mem_rdata) && !o_mem_we; endproperty
  a_complement_to_acc_op: assert property (p_complement_to_acc_op) else $error("complement to acc wrong");
  property p_mova; tk && i_op == 5'h0E |=>
    o_work_accumulator == $past(i_mem_rdata) && !o_zero_we; endproperty
  a_mova: assert property (p_mova) else $error("move to acc wrong");
endmodule
bind mie_core mie_core_chk #(.PC_W(PC_W)) u_chk (.*);

// ===== testbench/mie_mem_model.sv
`timescale 1ns/10ps
module mie_mem_model (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_mem_we,
  input  wire logic [7:0] i_mem_wdata,
  input  wire logic       i_carry_we,
  input  wire logic       i_carry_flag,
  output logic      [7:0] o_mem_rdata,
  output logic            o_carry
);
  // one data byte and the carry flag, changed only on strobes
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_mem_rdata <= 8'h00;
      o_carry     <= 1'b0;
    end else begin
      if (i_mem_we) o_mem_rdata <= i_mem_wdata;
      if (i_carry_we) o_carry <= i_carry_flag;
    end
  end
endmodule

// ===== testbench/mcu_core_instruction_execute_subset_tb.sv
`timescale 1ns/10ps
module mcu_core_instruction_execute_subset_tb;
  logic        i_clock = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_valid = 1'b0;
  logic        i_aux_carry = 1'b0;
  logic        i_wake = 1'b0;
  logic [4:0]  i_op = 5'h00;
  logic [7:0]  i_imm = 8'h00;
  logic [2:0]  i_bit = 3'h0;
  logic [12:0] i_target = 13'h0000;
  logic [12:0] i_pc = 13'h0000;
  logic        i_carry, o_ready, o_mem_we, o_zero_we, o_zero_flag, o_carry_we, o_carry_flag;
  logic        o_pc_load, o_stack_push, o_watchdog_clear, o_prescaler_clear, ew, c1;
  logic        o_timeout_flag, o_powerdown_flag, o_clock_gate_off;
  logic [7:0]  i_mem_rdata, o_work_accumulator, o_mem_wdata, em, ea, mem_v, acc_v;
  logic [12:0] o_pc_next, o_stack_data;
  logic [4:0]  op;
  logic [31:0] seed = 32'h00001E0A;
  logic [31:0] r;
  int          n_errors = 0;
  int          compares = 0;
  logic [4:0]  ops [10] = '{5'h03, 5'h04, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0C, 5'h0D, 5'h0E};
  logic [7:0]  corner [10] = '{8'h5A, 8'hFF, 8'hFF, 8'hFF, 8'hAB, 8'h01, 8'h01, 8'hFF, 8'hFF, 8'h3C};
  always #2 i_clock = ~i_clock;
  mie_core i_dut (.*);
  mie_mem_model i_mem (
    .i_clock     (i_clock),
    .i_rst_n     (i_rst_n),
    .i_mem_we    (o_mem_we),
    .i_mem_wdata (o_mem_wdata),
    .i_carry_we  (o_carry_we),
    .i_carry_flag(o_carry_flag),
    .o_mem_rdata (i_mem_rdata),
    .o_carry     (i_carry)
  );
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [8:0] daa(input logic [7:0] a, input logic c, input logic h);
    logic [8:0] s;
    s = {1'b0, a};
    if (a[3:0] > 4'h9 || h) s = s + 9'h006;
    if (a[7:4] > 4'h9 || c) s = s + 9'h060;
    return {s[8] | c, s[7:0]};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // hold the request until an edge sees ready, then look mid-cycle
  task automatic issue(input logic [4:0] code, input logic [7:0] imm);
    int k;
    k = 0;
    @(posedge i_clock);
    i_valid <= 1'b1;
    i_op <= code;
    i_imm <= imm;
    do begin
      @(posedge i_clock);
      k++;
    end while (o_ready !== 1'b1 && k < 9);
    if (k == 9) check(1'b0, 1'b1);
    i_valid <= 1'b0;
    @(negedge i_clock);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      r = rnd();
      op = ops[n % 10];
      mem_v = (n < 10) ? corner[n] : r[7:0];
      acc_v = (n < 10) ? corner[n] : r[31:24];
      @(posedge i_clock);
      i_aux_carry <= r[8];
      i_bit <= r[11:9];
      issue(5'h0F, mem_v);
      check(o_work_accumulator, mem_v);
      issue(5'h10, mem_v);
      check({o_mem_we, o_mem_wdata}, {1'b1, mem_v});
      issue(5'h0F, acc_v);
      check(o_work_accumulator, acc_v);
      em = mem_v;
      ea = acc_v;
      ew = 1'b1;
      c1 = 1'b0;
      case (op)
        5'h03: em = 8'h00;
        5'h04: em[r[11:9]] = 1'b0;
        5'h06: em = ~mem_v;
        5'h07: {ew, ea} = {1'b0, ~mem_v};
        5'h08: {c1, em} = daa(acc_v, i_carry, r[8]);
        5'h09: em = mem_v - 8'h01;
        5'h0A: {ew, ea} = {1'b0, mem_v - 8'h01};
        5'h0C: em = mem_v + 8'h01;
        5'h0D: {ew, ea} = {1'b0, mem_v + 8'h01};
        default: {ew, ea} = {1'b0, mem_v};
      endcase
      issue(op, acc_v);
      check(o_mem_we, ew);
      check(o_ready, 1'b1);
      if (ew) check(o_mem_wdata, em);
      check(o_work_accumulator, ea);
      check(o_carry_we, op == 5'h08);
      if (op == 5'h08) check(o_carry_flag, c1);
      check(o_zero_we, op inside {5'h06, 5'h07, 5'h09, 5'h0A, 5'h0C, 5'h0D});
      if (op inside {5'h06, 5'h07, 5'h09, 5'h0A, 5'h0C, 5'h0D}) begin
        check(o_zero_flag, (ew ? em : ea) == 8'h00);
      end
    end
    $display("random ops done");
    @(posedge i_clock);
    i_pc <= 13'h1FFF;
    i_target <= r[12:0];
    issue(5'h01, acc_v);
    check({o_pc_load, o_stack_push, o_ready, o_stack_data}, {3'h6, 13'h0000});
    check(o_pc_next, r[12:0]);
    check({o_zero_we, o_carry_we, o_mem_we, o_work_accumulator}, {3'h0, ea});
    @(posedge i_clock);
    i_target <= ~r[12:0];
    issue(5'h02, acc_v);
    check({o_pc_load, o_stack_push, o_pc_next}, {2'h2, ~r[12:0]});
    check({o_zero_we, o_carry_we, o_mem_we, o_ready}, 4'h0);
    @(negedge i_clock);
    check(o_ready, 1'b1);
    issue(5'h0B, acc_v);
    check({o_clock_gate_off, o_powerdown_flag, o_timeout_flag, o_prescaler_clear,
           o_watchdog_clear, o_ready}, 6'h36);
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    check({o_clock_gate_off, o_ready, o_work_accumulator}, {2'h2, ea});
    @(posedge i_clock);
    i_wake <= 1'b1;
    issue(5'h05, acc_v);
    check({o_powerdown_flag, o_timeout_flag, o_watchdog_clear, o_prescaler_clear}, 4'h2);
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(negedge i_clock);
    check({o_ready, o_work_accumulator, o_mem_we, o_pc_load}, 11'h000);
    issue(5'h0F, 8'hC3);
    check(o_work_accumulator, 8'hC3);
    $display("branch, halt and reset done");
    report_and_stop();
  end
endmodule
